// >>> hw/ppcs_cfg.svh
// Register offsets, field positions, reset values for the printer port block
`ifndef PPCS_CFG_SVH
`define PPCS_CFG_SVH
`define PPCS_OFF_CTRL     12'h000
`define PPCS_OFF_STAT     12'h004
`define PPCS_OFF_MODE     12'h008
`define PPCS_OFF_EVT      12'h00C
`define PPCS_OFF_EVT_CLR  12'h010
`define PPCS_OFF_EVT_EN   12'h014
`define PPCS_CTRL_STROBE  0
`define PPCS_CTRL_AUTOFD  1
`define PPCS_CTRL_INIT    2
`define PPCS_CTRL_SELECT  3
`define PPCS_CTRL_IRQEN   4
`define PPCS_STAT_FAULT   3
`define PPCS_STAT_ONLINE  4
`define PPCS_STAT_PAPER   5
`define PPCS_STAT_ACK     6
`define PPCS_STAT_BUSY    7
`define PPCS_CTRL_RESET   5'h04
`define PPCS_SYNC_RESET   5'h0b
`define PPCS_EVT_ACK      0
`define PPCS_EVT_FAULT    1
`define PPCS_EVT_PAPER    2
`define PPCS_NUM_EVT      3
`endif

// >>> hw/ppcs_evt.sv
// Sticky event bits with set and clear, one bit per generate entry
`timescale 1ns/1ps
`default_nettype none
module ppcs_evt #(
  parameter int N = 3
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [N-1:0] evt_set,
  input  wire logic [N-1:0] evt_clr,
  output var  logic [N-1:0] evt_q
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      // Set wins over clear
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          evt_q[i] <= 1'b0;
        end else if (evt_set[i]) begin
          evt_q[i] <= 1'b1;
        end else if (evt_clr[i]) begin
          evt_q[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule // ppcs_evt
`default_nettype wire

// >>> hw/ppcs_pkg.sv
// Types shared by the printer port block
package ppcs_pkg;
  typedef enum logic [1:0] {
    PPCS_MODE_STD = 2'b00,
    PPCS_MODE_EPP = 2'b01,
    PPCS_MODE_ECP = 2'b10
  } ppcs_mode_t;
endpackage

// >>> hw/ppcs_port.sv
// Standard-mode printer port control and status with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "ppcs_cfg.svh"
module ppcs_port (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        busy_in,
  input  wire logic        printer_took_data_in,
  input  wire logic        paper_out_in,
  input  wire logic        printer_online_in,
  input  wire logic        printer_fault_in,
  output var  logic        printer_select_out,
  output var  logic        printer_initialise_out,
  output var  logic        auto_line_feed_out,
  output var  logic        data_latch_pulse_out,
  output var  logic        pins_owned,
  output var  logic        port_irq_line_b,
  output var  logic        irq
);
  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [4:0] pin_raw;
  logic [4:0] pin_s;
  assign pin_raw = {busy_in, printer_took_data_in, paper_out_in,
                    printer_online_in, printer_fault_in};
  ppcs_sync #(.W(5), .RST_VAL(`PPCS_SYNC_RESET)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (pin_raw),
    .sync_out (pin_s)
  );
  wire busy_s   = pin_s[4];
  wire ack_s    = pin_s[3];
  wire paper_s  = pin_s[2];
  wire online_s = pin_s[1];
  wire fault_s  = pin_s[0];

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [4:0]               ctrl_q;
  ppcs_pkg::ppcs_mode_t     mode_q;
  logic [`PPCS_NUM_EVT-1:0] evt_en_q;
  logic [`PPCS_NUM_EVT-1:0] evt_q;
  logic [`PPCS_NUM_EVT-1:0] evt_clr;
  logic [`PPCS_NUM_EVT-1:0] evt_set;
  logic                     ack_prev_q;
  logic                     fault_prev_q;
  logic                     paper_prev_q;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire wr_en     = psel & penable & pwrite & pready;
  wire rd_en     = psel & penable & ~pwrite & pready;
  wire hit_ctrl  = paddr == `PPCS_OFF_CTRL;
  wire hit_stat  = paddr == `PPCS_OFF_STAT;
  wire hit_mode  = paddr == `PPCS_OFF_MODE;
  wire hit_evt   = paddr == `PPCS_OFF_EVT;
  wire hit_clr   = paddr == `PPCS_OFF_EVT_CLR;
  wire hit_en    = paddr == `PPCS_OFF_EVT_EN;
  wire hit_any   = hit_ctrl | hit_stat | hit_mode | hit_evt | hit_clr | hit_en;
  wire std_mode  = mode_q == ppcs_pkg::PPCS_MODE_STD;

  logic [7:0] stat_val;
  assign stat_val[`PPCS_STAT_BUSY]   = ~busy_s;
  assign stat_val[`PPCS_STAT_ACK]    = ack_s;
  assign stat_val[`PPCS_STAT_PAPER]  = paper_s;
  assign stat_val[`PPCS_STAT_ONLINE] = online_s;
  assign stat_val[`PPCS_STAT_FAULT]  = fault_s;
  assign stat_val[2:0]               = 3'b000;

  logic [31:0] rd_mux;
  assign rd_mux = hit_ctrl ? {27'h000_0000, ctrl_q} :
                  hit_stat ? {24'h00_0000, stat_val} :
                  hit_mode ? {30'h0000_0000, mode_q} :
                  hit_evt  ? {29'h0000_0000, evt_q} :
                  hit_en   ? {29'h0000_0000, evt_en_q} :
                  32'h0000_0000;

  // Events: falling acknowledge, falling fault, rising paper out
  assign evt_set = {paper_s & ~paper_prev_q, ~fault_s & fault_prev_q, ~ack_s & ack_prev_q};
  assign evt_clr = (wr_en && hit_clr) ? pwdata[`PPCS_NUM_EVT-1:0] : '0;

  ppcs_evt #(.N(`PPCS_NUM_EVT)) u_evt (
    .pclk    (pclk),
    .presetn (presetn),
    .evt_set (evt_set),
    .evt_clr (evt_clr),
    .evt_q   (evt_q)
  );

  // ---------------------------------------------------------------
  // Bus slave: one wait state, answer in second access cycle
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit_any;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= `PPCS_CTRL_RESET;
      mode_q   <= ppcs_pkg::PPCS_MODE_STD;
      evt_en_q <= '0;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        ctrl_q <= pwdata[4:0];
      end
      if (hit_mode) begin
        mode_q <= ppcs_pkg::ppcs_mode_t'(pwdata[1:0]);
      end
      if (hit_en) begin
        evt_en_q <= pwdata[`PPCS_NUM_EVT-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_prev_q   <= 1'b1;
      fault_prev_q <= 1'b1;
      paper_prev_q <= 1'b0;
    end else begin
      ack_prev_q   <= ack_s;
      fault_prev_q <= fault_s;
      paper_prev_q <= paper_s;
    end
  end

  // ---------------------------------------------------------------
  // Pin outputs, registered
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      printer_select_out     <= 1'b1;
      printer_initialise_out <= 1'b1;
      auto_line_feed_out     <= 1'b1;
      data_latch_pulse_out   <= 1'b1;
      pins_owned             <= 1'b1;
      port_irq_line_b        <= 1'b0;
      irq                    <= 1'b0;
    end else begin
      printer_select_out     <= ~ctrl_q[`PPCS_CTRL_SELECT];
      printer_initialise_out <= ctrl_q[`PPCS_CTRL_INIT];
      auto_line_feed_out     <= ~ctrl_q[`PPCS_CTRL_AUTOFD];
      data_latch_pulse_out   <= ~ctrl_q[`PPCS_CTRL_STROBE];
      pins_owned             <= std_mode;
      port_irq_line_b        <= ctrl_q[`PPCS_CTRL_IRQEN] & ~ack_s & std_mode;
      irq                    <= |(evt_q & evt_en_q);
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_select;
    @(posedge pclk) disable iff (!presetn)
      printer_select_out == !$past(ctrl_q[`PPCS_CTRL_SELECT]);
  endproperty
  a_select: assert property (p_select) else $error("select wrong");

  property p_init;
    @(posedge pclk) disable iff (!presetn)
      $rose(ctrl_q[`PPCS_CTRL_INIT]) |=> printer_initialise_out;
  endproperty
  a_init: assert property (p_init) else $error("init wrong");

  property p_autofd;
    @(posedge pclk) disable iff (!presetn)
      ctrl_q[`PPCS_CTRL_AUTOFD] |=> !auto_line_feed_out;
  endproperty
  a_autofd: assert property (p_autofd) else $error("autofeed wrong");

  property p_strobe;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_ctrl && pwdata[`PPCS_CTRL_STROBE]) |=> ##1 !data_latch_pulse_out;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe wrong");

  property p_busy;
    @(posedge pclk) disable iff (!presetn)
      (rd_en && hit_stat) |-> prdata[`PPCS_STAT_BUSY] == !$past(busy_s);
  endproperty
  a_busy: assert property (p_busy) else $error("busy bit wrong");

  property p_ack;
    @(posedge pclk) disable iff (!presetn)
      (rd_en && hit_stat) |-> prdata[`PPCS_STAT_ACK] == $past(ack_s);
  endproperty
  a_ack: assert property (p_ack) else $error("ack bit wrong");

  property p_irq_gate;
    @(posedge pclk) disable iff (!presetn)
      !ctrl_q[`PPCS_CTRL_IRQEN] [*2] |-> !port_irq_line_b;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");

  property p_paper;
    @(posedge pclk) disable iff (!presetn)
      (rd_en && hit_stat) |-> prdata[`PPCS_STAT_PAPER] == $past(paper_s);
  endproperty
  a_paper: assert property (p_paper) else $error("paper bit wrong");

  property p_online;
    @(posedge pclk) disable iff (!presetn)
      (rd_en && hit_stat) |-> prdata[`PPCS_STAT_ONLINE] == $past(online_s);
  endproperty
  a_online: assert property (p_online) else $error("online bit wrong");

  property p_fault;
    @(posedge pclk) disable iff (!presetn)
      (rd_en && hit_stat) |-> prdata[`PPCS_STAT_FAULT] == $past(fault_s);
  endproperty
  a_fault: assert property (p_fault) else $error("fault bit wrong");

  property p_ctrl_wr;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_ctrl) |=> ctrl_q == $past(pwdata[4:0]);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("ctrl write lost");

  property p_release;
    @(posedge pclk) disable iff (!presetn)
      (mode_q != ppcs_pkg::PPCS_MODE_STD) |=> !pins_owned && !port_irq_line_b;
  endproperty
  a_release: assert property (p_release) else $error("pins not released");

  property p_init_eq;
    @(posedge pclk) disable iff (!presetn)
      printer_initialise_out == $past(ctrl_q[`PPCS_CTRL_INIT]);
  endproperty
  a_init_eq: assert property (p_init_eq) else $error("init level wrong");

  property p_autofd_eq;
    @(posedge pclk) disable iff (!presetn)
      auto_line_feed_out == !$past(ctrl_q[`PPCS_CTRL_AUTOFD]);
  endproperty
  a_autofd_eq: assert property (p_autofd_eq) else $error("autofeed level wrong");

  property p_strobe_eq;
    @(posedge pclk) disable iff (!presetn)
      data_latch_pulse_out == !$past(ctrl_q[`PPCS_CTRL_STROBE]);
  endproperty
  a_strobe_eq: assert property (p_strobe_eq) else $error("strobe level wrong");

  property p_irq_set;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_q[`PPCS_CTRL_IRQEN] && !ack_s && std_mode) |=> port_irq_line_b;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("port irq missing");

  property p_ctrl_rd;
    @(posedge pclk) disable iff (!presetn)
      (rd_en && hit_ctrl) |-> prdata[4:0] == $past(ctrl_q);
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl readback wrong");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
      irq == $past(|(evt_q & evt_en_q));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("event irq wrong");
endmodule // ppcs_port
`default_nettype wire

// >>> hw/ppcs_sync.sv
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ppcs_sync #(
  parameter int           W       = 5,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] pin_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Idle pin levels, so no false edge after reset
      meta_q   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q   <= pin_in;
      sync_out <= meta_q;
    end
  end
endmodule // ppcs_sync
`default_nettype wire

// >>> sim/ppcs_port_tb.sv
// Self-checking bench for the printer port block
`timescale 1ns/1ps
`default_nettype none
module ppcs_port_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        busy, ack_n, paper, online, fault_n, slow;
  logic        sel_n, init_o, feed_n, stb_n, owned, pirq, irq;
  logic [4:0]  c;
  logic [32:0] expq[$];
  int          n_errors, comparisons, pirq_cnt, pirq_mark;
  ppcs_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy_in(busy), .printer_took_data_in(ack_n),
    .paper_out_in(paper), .printer_online_in(online), .printer_fault_in(fault_n),
    .printer_select_out(sel_n), .printer_initialise_out(init_o),
    .auto_line_feed_out(feed_n), .data_latch_pulse_out(stb_n), .pins_owned(owned),
    .port_irq_line_b(pirq), .irq(irq));
  ppcs_printer_model prn (.pclk(pclk), .presetn(presetn), .slow(slow),
    .data_latch_pulse_out(stb_n), .auto_line_feed_out(feed_n), .busy_in(busy),
    .printer_took_data_in(ack_n));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(string what, logic [32:0] seen, logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic [32:0] exp);
    expq.push_back(exp);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge before the next setup
    @(posedge pclk);
  endtask
  task automatic wctl(logic [4:0] v);
    apb(1'b1, 12'h000, {27'h000_0000, v}, 33'h0_0000_0000);
    repeat (3) @(posedge pclk);
    chk("select", sel_n, !v[3]);
    chk("init", init_o, v[2]);
    chk("feed", feed_n, !v[1]);
    chk("strobe", stb_n, !v[0]);
  endtask
  // Scoreboard on each answer
  always @(posedge pclk) begin
    if (pready === 1'b1 && expq.size() > 0)
      chk("apb", {pslverr, prdata}, expq.pop_front());
    if (pirq === 1'b1) pirq_cnt++;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    close_out();
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0000_0000; paper = 1'b0; online = 1'b1; fault_n = 1'b1; slow = 1'b0;
    void'($urandom(18));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("irq", {pirq, irq, owned}, 3'h1);
    apb(1'b0, 12'h000, 32'h0000_0000, 33'h0_0000_0004);
    for (int i = 0; i < 6; i++) begin
      c = 5'($urandom) & 5'h0e;
      wctl(c);
      apb(1'b0, 12'h000, 32'h0000_0000, {28'h000_0000, c});
      {paper, online, fault_n} <= 3'($urandom);
      repeat (4) @(posedge pclk);
      apb(1'b0, 12'h004, 32'h0, {25'h0, 2'b11, paper, online, fault_n, 3'h0});
    end
    slow <= 1'b1;
    apb(1'b1, 12'h010, 32'h0000_0007, 33'h0_0000_0000);
    pirq_mark = pirq_cnt;
    wctl(5'h01);
    wctl(5'h00);
    apb(1'b0, 12'h004, 32'h0, {25'h0, 2'b01, paper, online, fault_n, 3'h0});
    repeat (50) @(posedge pclk);
    chk("pirq off", 33'(pirq_cnt - pirq_mark), 33'h0_0000_0000);
    apb(1'b0, 12'h00c, 32'h0000_0000, 33'h0_0000_0001);
    chk("irq masked", irq, 1'b0);
    apb(1'b1, 12'h014, 32'h0000_0007, 33'h0_0000_0000);
    repeat (3) @(posedge pclk);
    chk("irq on", irq, 1'b1);
    apb(1'b1, 12'h010, 32'h0000_0001, 33'h0_0000_0000);
    repeat (3) @(posedge pclk);
    chk("irq clear", irq, 1'b0);
    slow <= 1'b0;
    pirq_mark = pirq_cnt;
    // Line feed lengthens busy, so still busy at this read
    wctl(5'h13);
    wctl(5'h12);
    apb(1'b0, 12'h004, 32'h0, {25'h0, 2'b01, paper, online, fault_n, 3'h0});
    repeat (40) @(posedge pclk);
    // Six acknowledge-low cycles from the printer
    chk("pirq on", 33'(pirq_cnt - pirq_mark), 33'h0_0000_0006);
    apb(1'b1, 12'h008, 32'h0000_0001, 33'h0_0000_0000);
    repeat (3) @(posedge pclk);
    chk("owned", owned, 1'b0);
    apb(1'b0, 12'h008, 32'h0000_0000, 33'h0_0000_0001);
    apb(1'b1, 12'h008, 32'h0000_0000, 33'h0_0000_0000);
    apb(1'b1, 12'h020, 32'h0000_0001, 33'h1_0000_0000);
    apb(1'b0, 12'h020, 32'h0000_0000, 33'h1_0000_0000);
    repeat (3) @(posedge pclk);
    close_out();
  end
endmodule // ppcs_port_tb
`default_nettype wire

// >>> sim/ppcs_printer_model.sv
// Behavioural printer on the cable side of the port
`timescale 1ns/1ps
`default_nettype none
module ppcs_printer_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic slow,
  input  wire logic data_latch_pulse_out,
  input  wire logic auto_line_feed_out,
  output var  logic busy_in,
  output var  logic printer_took_data_in
);
  logic [7:0] cnt_q;
  logic       stb_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 8'h00;
      stb_q  <= 1'b1;
    end else begin
      stb_q <= data_latch_pulse_out;
      if (stb_q && !data_latch_pulse_out && cnt_q == 8'h00) begin
        cnt_q <= (slow ? 8'h28 : 8'h0c) + (auto_line_feed_out ? 8'h00 : 8'h08);
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
  assign busy_in = cnt_q > 8'h06;
  assign printer_took_data_in = !(cnt_q != 8'h00 && cnt_q <= 8'h06);
endmodule // ppcs_printer_model
`default_nettype wire
